/* hdl/gated_timer_counter_16bit.v */
//
// Contract
// - 16-bit count, byte writes update live count
// - source select: instruction clock or external
// - internal source: one count per prescaled cycle
// - counter mode counts external rising edges
// - falling edge needed before first counted rise
// - prescaler divides by 1, 2, 4, 8
// - prescaler hidden, cleared by count writes
// - crystal enable starts oscillator, runs asleep
// - crystal only with internal or low-power clock
// - crystal on forces pins to input
// - bypass bit skips instruction-cycle synchronisation
// - asynchronous mode counts and wakes in sleep
// - mode switch may drop or add count
// - byte reads valid while counting asynchronously
// - gate source: gate pin or comparator two
// - gate applies only when gate enabled
// - invert bit flips gate for either source
// - rollover to zero sets overflow flag
// - interrupt needs three enables plus flag
// - prescale codes 00..11 give 1..8
// - invert 1 counts high, 0 counts low
// - gate enable ignored while timer off
//
`timescale 1ns/1ns
`include "gated_timer_defs.vh"

module gated_timer_counter_16bit #(
    parameter INSTR_DIV = `INSTR_DIV
) (
    // clock and reset
    input wire ref_clk,
    input wire rst_n,
    // axi4-lite write address
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    // axi4-lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    // axi4-lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // axi4-lite read address
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    // axi4-lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // pins from outside the clock domain
    input wire externalCountInput,
    input wire crystalClockIn,
    input wire gatePin,
    input wire comparatorTwoOutput,
    // system state from same-clock logic
    input wire sleepMode,
    input wire internalOscillator,
    input wire lowPowerCrystalMode,
    input wire oscPinADirectionIn,
    input wire oscPinBDirectionIn,
    input wire oscPinADataIn,
    input wire oscPinBDataIn,
    // oscillator and pin control
    output reg crystalOscRun,
    output reg oscPinsForcedInput,
    // interrupt and wake
    output reg irqRequest,
    output reg wakeRequest
);

    localparam [2:0] DIV_LAST = INSTR_DIV[2:0] - 3'h1;

    // prescale code to terminal count
    function [2:0] presLast;
        input [1:0] code;
        begin
            case (code)
                2'b00: presLast = `PS_LAST_1;
                2'b01: presLast = `PS_LAST_2;
                2'b10: presLast = `PS_LAST_4;
                default: presLast = `PS_LAST_8;
            endcase
        end
    endfunction

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    reg [15:0] count_r;
    reg [7:0] ctrl_r;
    reg [7:0] cmpCtrl_r;
    reg overflowFlag_r;
    reg pieOvf_r;
    reg peripheral_irq_enable_r;
    reg gie_r;
    reg [2:0] presCnt_r;
    reg [2:0] divCnt_r;
    reg armed_r;
    reg pend_r;
    reg srcPrev_r;
    reg [3:0] syncA_r;
    reg [3:0] syncB_r;
    reg [3:0] syncC_r;
    reg [3:0] filt_r;
    reg [7:0] awAddr_r;
    reg awHave_r;
    reg [7:0] wData_r;
    reg wStrb_r;
    reg wHave_r;

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    wire [3:0] pinsIn;
    assign pinsIn = {comparatorTwoOutput, gatePin, crystalClockIn, externalCountInput};

    always @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            syncA_r <= 4'h0;
            syncB_r <= 4'h0;
            syncC_r <= 4'h0;
            filt_r <= 4'h0;
        end
        else
        begin
            syncA_r <= pinsIn;
            syncB_r <= syncA_r;
            syncC_r <= syncB_r;
            // level moves only once stages two and three agree
            filt_r <= (syncB_r & syncC_r) | (filt_r & (syncB_r | syncC_r));
        end
    end

    // ------------------------------------------------------------
    // clock source, gate and prescaler
    // ------------------------------------------------------------
    wire oscActive;
    wire extMode;
    wire asyncMode;
    wire srcLevel;
    wire srcRise;
    wire srcFall;
    wire instrTick;
    wire gateRaw;
    wire gateActive;
    wire runEn;
    wire rawTick;
    wire advance;
    wire wrFire;
    wire wrLo;
    wire wrHi;

    assign oscActive = ctrl_r[`CTL_OSC] & (internalOscillator | lowPowerCrystalMode);
    assign extMode = ctrl_r[`CTL_CS];
    assign asyncMode = extMode & ctrl_r[`CTL_SYNC];
    assign srcLevel = oscActive ? filt_r[1] : filt_r[0];
    assign srcRise = srcLevel & ~srcPrev_r;
    assign srcFall = ~srcLevel & srcPrev_r;
    assign instrTick = (divCnt_r == DIV_LAST);
    assign gateRaw = cmpCtrl_r[`CMP_GSS] ? filt_r[3] : filt_r[2];
    assign gateActive = ctrl_r[`CTL_GINV] ? gateRaw : ~gateRaw;
    assign runEn = ctrl_r[`CTL_ON] & (~ctrl_r[`CTL_GE] | gateActive);

    // internal and synchronised sources freeze in sleep, asynchronous does not
    assign rawTick = !extMode ? (instrTick & ~sleepMode) :
        asyncMode ? (srcRise & armed_r) :
        (pend_r & instrTick & ~sleepMode);
    assign advance = runEn & rawTick & (presCnt_r == presLast(ctrl_r[`CTL_PS_HI:`CTL_PS_LO]));

    assign wrFire = awHave_r & wHave_r & wStrb_r & ~s_axi_bvalid;
    assign wrLo = wrFire & (awAddr_r == `ADDR_CNT_LO);
    assign wrHi = wrFire & (awAddr_r == `ADDR_CNT_HI);

    always @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            divCnt_r <= 3'h0;
            srcPrev_r <= 1'b0;
            armed_r <= 1'b0;
            pend_r <= 1'b0;
            presCnt_r <= 3'h0;
        end
        else
        begin
            divCnt_r <= instrTick ? 3'h0 : divCnt_r + 3'h1;
            srcPrev_r <= srcLevel;
            // a falling edge arms the edge counter
            if (!extMode || !ctrl_r[`CTL_ON])
                armed_r <= 1'b0;
            else if (srcFall)
                armed_r <= 1'b1;
            // synchronised mode holds an edge until the next instruction cycle
            if (!extMode || asyncMode)
                pend_r <= 1'b0;
            else if (srcRise & armed_r)
                pend_r <= 1'b1;
            else if (instrTick & ~sleepMode)
                pend_r <= 1'b0;
            if (wrLo | wrHi)
                presCnt_r <= 3'h0;
            else if (runEn & rawTick)
                presCnt_r <= advance ? 3'h0 : presCnt_r + 3'h1;
        end
    end

    // ------------------------------------------------------------
    // count and overflow
    // ------------------------------------------------------------
    wire rollover;
    wire flagWrite;
    assign rollover = advance & (count_r == `CNT_MAX) & ~wrLo & ~wrHi;
    assign flagWrite = wrFire & (awAddr_r == `ADDR_FLAG);

    always @(posedge ref_clk)
    begin
        if (!rst_n)
            count_r <= `CNT_RST;
        else if (wrLo)
            count_r <= {count_r[15:8], wData_r};
        else if (wrHi)
            count_r <= {wData_r, count_r[7:0]};
        else if (advance)
            count_r <= count_r + 16'h0001;
    end

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    always @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            ctrl_r <= `CTRL_RST;
            cmpCtrl_r <= `CMP_RST;
            overflowFlag_r <= 1'b0;
            pieOvf_r <= 1'b0;
            peripheral_irq_enable_r <= 1'b0;
            gie_r <= 1'b0;
        end
        else
        begin
            if (wrFire & (awAddr_r == `ADDR_CTRL))
                ctrl_r <= wData_r;
            if (wrFire & (awAddr_r == `ADDR_CMP_CTRL))
                cmpCtrl_r <= wData_r;
            if (wrFire & (awAddr_r == `ADDR_PIE))
                pieOvf_r <= wData_r[`PIE_OVF];
            if (wrFire & (awAddr_r == `ADDR_IRQ_CTRL))
            begin
                peripheral_irq_enable_r <= wData_r[`IRQ_PERIPHERAL_IRQ_ENABLE];
                gie_r <= wData_r[`IRQ_GIE];
            end
            // hardware set wins over a software clear in the same cycle
            if (rollover)
                overflowFlag_r <= 1'b1;
            else if (flagWrite)
                overflowFlag_r <= wData_r[`FLAG_OVF];
        end
    end

    // ------------------------------------------------------------
    // interrupt, wake and oscillator outputs
    // ------------------------------------------------------------
    always @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            irqRequest <= 1'b0;
            wakeRequest <= 1'b0;
            crystalOscRun <= 1'b0;
            oscPinsForcedInput <= 1'b0;
        end
        else
        begin
            irqRequest <= overflowFlag_r & pieOvf_r & peripheral_irq_enable_r & gie_r;
            wakeRequest <= overflowFlag_r & pieOvf_r & peripheral_irq_enable_r & sleepMode;
            crystalOscRun <= oscActive;
            oscPinsForcedInput <= oscActive;
        end
    end

    // ------------------------------------------------------------
    // axi4-lite write channel
    // ------------------------------------------------------------
    always @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            awAddr_r <= `BYTE_ZERO;
            awHave_r <= 1'b0;
            wData_r <= `BYTE_ZERO;
            wStrb_r <= 1'b0;
            wHave_r <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
        end
        else
        begin
            s_axi_awready <= ~awHave_r & ~(s_axi_awvalid & s_axi_awready);
            s_axi_wready <= ~wHave_r & ~(s_axi_wvalid & s_axi_wready);
            if (s_axi_awvalid & s_axi_awready)
            begin
                awAddr_r <= s_axi_awaddr;
                awHave_r <= 1'b1;
            end
            if (s_axi_wvalid & s_axi_wready)
            begin
                wData_r <= s_axi_wdata[7:0];
                wStrb_r <= s_axi_wstrb[0];
                wHave_r <= 1'b1;
            end
            if (awHave_r & wHave_r & ~s_axi_bvalid)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (awAddr_r > `ADDR_PIN_VIEW) || (awAddr_r[1:0] != 2'b00) ?
                    `RESP_SLVERR : `RESP_OKAY;
                awHave_r <= 1'b0;
                wHave_r <= 1'b0;
            end
            else if (s_axi_bvalid & s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // axi4-lite read channel
    // ------------------------------------------------------------
    reg [7:0] rdByte;
    reg rdOk;
    always @*
    begin
        rdByte = `BYTE_ZERO;
        rdOk = 1'b1;
        case (s_axi_araddr)
            `ADDR_CNT_LO: rdByte = count_r[7:0];
            `ADDR_CNT_HI: rdByte = count_r[15:8];
            `ADDR_CTRL: rdByte = ctrl_r;
            `ADDR_CMP_CTRL: rdByte = cmpCtrl_r;
            `ADDR_FLAG: rdByte[`FLAG_OVF] = overflowFlag_r;
            `ADDR_PIE: rdByte[`PIE_OVF] = pieOvf_r;
            `ADDR_IRQ_CTRL:
            begin
                rdByte[`IRQ_PERIPHERAL_IRQ_ENABLE] = peripheral_irq_enable_r;
                rdByte[`IRQ_GIE] = gie_r;
            end
            `ADDR_PIN_VIEW:
            begin
                rdByte[`VIEW_DATA_A] = oscPinADataIn & ~oscActive;
                rdByte[`VIEW_DATA_B] = oscPinBDataIn & ~oscActive;
                rdByte[`VIEW_DIR_A] = oscPinADirectionIn | oscActive;
                rdByte[`VIEW_DIR_B] = oscPinBDirectionIn | oscActive;
            end
            default: rdOk = 1'b0;
        endcase
    end

    always @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
            if (s_axi_arvalid & s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= {24'h000000, rdByte};
                s_axi_rresp <= rdOk ? `RESP_OKAY : `RESP_SLVERR;
            end
            else if (s_axi_rvalid & s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

endmodule // gated_timer_counter_16bit

/* shared/gated_timer_defs.vh */
`ifndef GATED_TIMER_DEFS_VH
`define GATED_TIMER_DEFS_VH

// register byte addresses
`define ADDR_CNT_LO 8'h00
`define ADDR_CNT_HI 8'h04
`define ADDR_CTRL 8'h08
`define ADDR_CMP_CTRL 8'h0c
`define ADDR_FLAG 8'h10
`define ADDR_PIE 8'h14
`define ADDR_IRQ_CTRL 8'h18
`define ADDR_PIN_VIEW 8'h1c

// control register fields
`define CTL_ON 0
`define CTL_CS 1
`define CTL_SYNC 2
`define CTL_OSC 3
`define CTL_PS_LO 4
`define CTL_PS_HI 5
`define CTL_GE 6
`define CTL_GINV 7

// other register fields
`define CMP_GSS 1
`define FLAG_OVF 0
`define PIE_OVF 0
`define IRQ_PERIPHERAL_IRQ_ENABLE 6
`define IRQ_GIE 7
`define VIEW_DATA_A 0
`define VIEW_DATA_B 1
`define VIEW_DIR_A 2
`define VIEW_DIR_B 3

// reset values
`define CTRL_RST 8'h00
`define CMP_RST 8'h02
`define BYTE_ZERO 8'h00
`define CNT_RST 16'h0000
`define CNT_MAX 16'hffff

// prescaler terminal counts per ratio
`define PS_LAST_1 3'h0
`define PS_LAST_2 3'h1
`define PS_LAST_4 3'h3
`define PS_LAST_8 3'h7

// timing
`define INSTR_DIV 4
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

/* testbench/ext_clock_source.sv */
`timescale 1ns/1ns
module ext_clock_source #(
    parameter int XTAL_HALF = 40,
    parameter int PULSE_HALF = 48
) (
    // pins toward the timer
    output logic countPin,
    output logic crystalClk,
    // crystal run state from the timer
    input wire logic xtalRun
);
    // both pins rest low; the crystal stands still while stopped
    initial countPin = 1'b0;
    initial crystalClk = 1'b0;
    always #(XTAL_HALF) crystalClk = xtalRun & ~crystalClk;
    // a rise with no falling edge before it
    task automatic lift();
        // step off the sampling edge of the system clock
        #1;
        countPin = 1'b1;
        #(PULSE_HALF);
    endtask
    task automatic pulses(input logic [7:0] n);
        repeat (n)
        begin
            countPin = 1'b0;
            #(PULSE_HALF);
            countPin = 1'b1;
            #(PULSE_HALF);
        end
        // rest low so that the next lift is an unarmed rise
        countPin = 1'b0;
        #(PULSE_HALF);
    endtask
endmodule // ext_clock_source

/* testbench/gated_timer_counter_16bit_test.sv */
`timescale 1ns/1ns
`include "gated_timer_defs.vh"
module gated_timer_counter_16bit_test;
    logic ref_clk, rst_n, irqRequest, wakeRequest;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rdv, n;
    logic [3:0] s_axi_wstrb, view;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic externalCountInput, crystalClockIn, gatePin, comparatorTwoOutput, sleepMode;
    logic internalOscillator, lowPowerCrystalMode, crystalOscRun, oscPinsForcedInput;
    logic oscPinADirectionIn, oscPinBDirectionIn, oscPinADataIn, oscPinBDataIn;
    int n_errors, num_checks;
    gated_timer_counter_16bit gated_timer_counter_16bit_i (.*);
    ext_clock_source ext_clock_source_i (.countPin(externalCountInput),
        .crystalClk(crystalClockIn), .xtalRun(crystalOscRun));
    function automatic logic [7:0] expCount(input int ps, input int cyc, input logic open);
        return open ? 8'((cyc + 4) / (`INSTR_DIV << ps)) : 8'h00;
    endfunction
    task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // count may differ by one from the instruction-tick phase
    task automatic near(input logic [7:0] e);
        chk({33'h0, 8'(rdv[7:0] + 8'h1 - e) <= 8'h2}, 34'h1);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge ref_clk);
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end while (!(s_axi_bvalid && s_axi_bready));
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge ref_clk);
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end while (!(s_axi_rvalid && s_axi_rready));
        rdv = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic run(input logic [7:0] ctl, input int cyc);
        wr(`ADDR_CTRL, 8'h00);
        wr(`ADDR_CNT_LO, 8'h00);
        wr(`ADDR_CNT_HI, 8'h00);
        wr(`ADDR_CTRL, ctl);
        repeat (cyc) @(posedge ref_clk);
        wr(`ADDR_CTRL, 8'h00);
        rd(`ADDR_CNT_LO);
    endtask
    task automatic results();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        n_errors++;
        results();
    end
    initial
    begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'hf;
        {gatePin, comparatorTwoOutput, sleepMode, lowPowerCrystalMode} = 4'h0;
        internalOscillator = 1'b1;
        view = 4'($urandom(60244));
        {oscPinBDirectionIn, oscPinADirectionIn, oscPinBDataIn, oscPinADataIn} = view;
        rst_n = 1'b0;
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd(`ADDR_CMP_CTRL);
        chk(rdv, `CMP_RST);
        rd(`ADDR_CNT_HI);
        chk(rdv, `BYTE_ZERO);
        rd(8'h20);
        chk({resp, rdv}, {`RESP_SLVERR, 32'h0});
        wr(8'h24, 8'h5a);
        chk(resp, `RESP_SLVERR);
        n = $urandom;
        wr(`ADDR_CNT_LO, n[7:0]);
        wr(`ADDR_CNT_HI, n[15:8]);
        rd(`ADDR_CNT_LO);
        chk(rdv, n[7:0]);
        rd(`ADDR_CNT_HI);
        chk(rdv, n[15:8]);
        s_axi_wstrb <= 4'h0;
        wr(`ADDR_CNT_LO, ~n[7:0]);
        s_axi_wstrb <= 4'hf;
        rd(`ADDR_CNT_LO);
        chk(rdv, n[7:0]);
        for (int ps = 0; ps < 4; ps++)
        begin
            run({2'h0, 2'(ps), 4'h1}, 32 << ps);
            near(expCount(ps, 32 << ps, 1'b1));
        end
        run(8'h40, 64);
        chk(rdv, `BYTE_ZERO);
        for (int k = 0; k < 16; k++)
        begin
            @(posedge ref_clk);
            gatePin <= k[0] ? !k[2] : k[2];
            comparatorTwoOutput <= k[0] ? k[2] : !k[2];
            wr(`ADDR_CMP_CTRL, {6'h0, k[0], 1'b0});
            run({k[1], k[3], 6'h1}, 32);
            near(expCount(0, 32, !k[3] || (k[1] ? k[2] : !k[2])));
        end
        wr(`ADDR_CNT_HI, 8'hff);
        wr(`ADDR_CNT_LO, 8'hfe);
        wr(`ADDR_CTRL, 8'h01);
        repeat (20) @(posedge ref_clk);
        wr(`ADDR_CTRL, 8'h00);
        rd(`ADDR_FLAG);
        chk(rdv, 32'h1);
        wr(`ADDR_FLAG, 8'h00);
        rd(`ADDR_FLAG);
        chk(rdv, 32'h0);
        sleepMode <= 1'b1;
        for (int m = 0; m < 8; m++)
        begin
            wr(`ADDR_PIE, {7'h0, m[0]});
            wr(`ADDR_IRQ_CTRL, {m[2], m[1], 6'h0});
            wr(`ADDR_FLAG, 8'h01);
            repeat (2) @(posedge ref_clk);
            chk({irqRequest, wakeRequest}, {&m[2:0], m[0] & m[1]});
        end
        wr(`ADDR_FLAG, 8'h00);
        sleepMode <= 1'b0;
        for (int b = 0; b < 2; b++)
        begin
            wr(`ADDR_CTRL, 8'h00);
            wr(`ADDR_CNT_LO, 8'h00);
            n = $urandom_range(9, 2);
            wr(`ADDR_CTRL, {5'h0, b[0], 2'h3});
            ext_clock_source_i.lift();
            ext_clock_source_i.pulses(n[7:0]);
            repeat (12) @(posedge ref_clk);
            rd(`ADDR_CNT_LO);
            chk(rdv, n[7:0]);
        end
        wr(`ADDR_CTRL, 8'h08);
        rd(`ADDR_PIN_VIEW);
        chk({crystalOscRun, oscPinsForcedInput, rdv[3:0]}, 6'h3c);
        internalOscillator <= 1'b0;
        repeat (4) @(posedge ref_clk);
        chk({crystalOscRun, oscPinsForcedInput}, 2'h0);
        rd(`ADDR_PIN_VIEW);
        chk(rdv[3:0], view);
        lowPowerCrystalMode <= 1'b1;
        wr(`ADDR_CNT_LO, 8'h00);
        repeat (50) @(posedge ref_clk);
        chk(crystalOscRun, 1'b1);
        sleepMode <= 1'b1;
        wr(`ADDR_CTRL, 8'h0f);
        repeat (400) @(posedge ref_clk);
        wr(`ADDR_CTRL, 8'h08);
        sleepMode <= 1'b0;
        rd(`ADDR_CNT_LO);
        chk(rdv[7:0] > 8'h0f && rdv[7:0] < 8'h16, 1'b1);
        results();
    end
endmodule // gated_timer_counter_16bit_test

/* testbench/gated_timer_monitor.sv */
`timescale 1ns/1ns
module gated_timer_monitor (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // register bus handshakes
    input wire logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
    input wire logic s_axi_bvalid, s_axi_arvalid, s_axi_arready,
    input wire logic s_axi_rvalid, s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    // oscillator, sleep and wake
    input wire logic internalOscillator, lowPowerCrystalMode, sleepMode,
    input wire logic crystalOscRun, oscPinsForcedInput, wakeRequest
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // ----------------------------------------
    // bus steps
    // ----------------------------------------
    sequence s_write_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_read_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    a_write_answered: assert property (s_write_taken |-> ##2 s_axi_bvalid)
        else $error("write not answered");
    a_write_refused: assert property (s_write_taken |=> !s_axi_awready && !s_axi_wready)
        else $error("ready high right after a write take");
    a_read_answered: assert property (s_read_taken |=> s_axi_rvalid)
        else $error("read not answered");
    a_read_released: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read data held after handshake");
    a_read_byte: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("upper read data not zero");
    a_read_single: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("second read accepted");
    a_osc_permitted: assert property ($rose(crystalOscRun) |->
        $past(internalOscillator) || $past(lowPowerCrystalMode))
        else $error("crystal started without permission");
    a_pins_follow: assert property (oscPinsForcedInput == crystalOscRun)
        else $error("pin forcing differs from crystal state");
    a_osc_dropped: assert property (!internalOscillator && !lowPowerCrystalMode |=>
        !crystalOscRun)
        else $error("crystal running without permission");
    a_wake_sleep: assert property (wakeRequest |-> $past(sleepMode))
        else $error("wake request while awake");
endmodule // gated_timer_monitor

bind gated_timer_counter_16bit gated_timer_monitor gated_timer_monitor_i (.*);
